// ---- hdl/sdf_pkg.sv ----
// Constants, bus carriers and sequencer states for the sigma-delta back end
package sdf_pkg;
    localparam int unsigned CLK_HZ      = 25000000;
    localparam int unsigned CLK_NS      = 1000000000 / CLK_HZ;
    localparam int unsigned MOD_HZ      = 614400;
    localparam int unsigned MOD_DIV     = CLK_HZ / MOD_HZ;
    localparam int unsigned N_SAMPLES   = 201;
    localparam int unsigned N_CH        = 8;
    localparam int unsigned RST_NS      = 14600;
    localparam int unsigned RST_CYC     = (RST_NS + CLK_NS - 1) / CLK_NS;
    // Modulator register plus two synchroniser stages after reset release
    localparam int unsigned SETTLE_CYC  = 3;
    localparam int unsigned SLOT_NS     = 480300;
    localparam int unsigned SLOT_CYC    = SLOT_NS / CLK_NS;
    localparam int unsigned LINE50_US   = 20000;
    localparam int unsigned LINE60_US   = 16670;
    localparam int unsigned Q50_CYC     = LINE50_US * (CLK_HZ / 1000000) / 4;
    localparam int unsigned Q60_CYC     = LINE60_US * (CLK_HZ / 1000000) / 4;
    localparam int unsigned PHASE_DEG   = 5;
    localparam int unsigned QUAD_DEG    = 90;
    localparam logic [2:0]  FILL_SCANS  = 3'h4;
    localparam logic [7:0]  A_CTRL      = 8'h00;
    localparam logic [7:0]  A_CCR       = 8'h04;
    localparam logic [7:0]  A_STAT      = 8'h08;
    localparam logic [7:0]  A_RES       = 8'h40;
    localparam logic [7:0]  A_OFF       = 8'h80;
    localparam logic [7:0]  A_POS       = 8'ha0;
    localparam logic [7:0]  A_NEG       = 8'hc0;
    localparam int unsigned C_HUM       = 0;
    localparam int unsigned C_SEL60     = 1;
    localparam int unsigned C_NACT      = 2;
    localparam int unsigned C_SUP       = 12;
    localparam logic [1:0]  CAL_NONE    = 2'h0;
    localparam logic [1:0]  CAL_ZERO    = 2'h1;
    localparam logic [1:0]  CAL_POS     = 2'h2;
    localparam logic [1:0]  CAL_NEG     = 2'h3;
    localparam logic [23:0] OFF_RESET   = 24'h000000;
    localparam logic [23:0] GAIN_RESET  = 24'h800000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RST  = 4'h2,
        ST_INT  = 4'h4,
        ST_WAIT = 4'h8
    } seq_state_type;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_type;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_type;
endpackage

// ---- hdl/sigma_delta_filter_cal_sequencer.sv ----
// Integrating filter, hum averaging and calibration sequencer with Wishbone slave
// How it works
// (R01) Each conversion counts 201 modulator bits taken at about 614 kHz.
// (R02) Filter shares modulator clock and reset; cutoff near 2 kHz.
// (R03) Finished result goes to hum averaging if on, else to calibration.
// (R04) Hum line cycle is 20 ms or 16.67 ms, chosen by control bit.
// (R05) Four equal samples per line cycle at 5, 95, 185, 275 degrees.
// (R06) 4x8 sample array, same-phase replacement, summed each quarter cycle.
// (R07) Averaged results count only after four scans fill the array.
// (R08) Hum on: every scan converts all eight channels, 5 or 4.167 ms.
// (R09) Hum off: only active channels converted, about 260.3 per second.
// (R10) Offset, positive gain and negative gain stores shape every result.
// (R11) Host calibrates zero scale before either gain point.
// (R12) Offset 000000 with gains 800000 leaves results uncalibrated.
// (R13) Host recalibrates after changing gain or range.
// (R14) Suppress bit withholds scan interrupt while active channel calibrates.
// (R15) Busy pin high while any active channel is calibrating.
// (R16) Calibration store access halts, resets filter, clears interrupt, restarts.
// (R17) A calibration point takes one line cycle, or one slot per channel.
// (R18) Host requests calibration by writing the channel's mode field.
// (R19) Flagged conversion goes to calibration store, then mode field clears.
// (R20) Interrupt raised at end of scan, cleared by a result read.
`timescale 1ns/1ns
module sigma_delta_filter_cal_sequencer #(
    parameter int unsigned SLOT_CYC = sdf_pkg::SLOT_CYC,
    parameter int unsigned Q50_CYC  = sdf_pkg::Q50_CYC,
    parameter int unsigned Q60_CYC  = sdf_pkg::Q60_CYC,
    parameter int unsigned MOD_DIV  = sdf_pkg::MOD_DIV
) (
    input  wire logic               clk_i,
    input  wire logic               nrst_i,
    input  wire logic               mod_bit_i,
    input  wire sdf_pkg::wb_req_type wb_req_i,
    output sdf_pkg::wb_rsp_type     wb_rsp_o,
    output logic                    mod_reset_o,
    output logic                    tuning_busy_pin_o,
    output logic                    scan_done_irq_n_o
);
    localparam int unsigned OFF50 = Q50_CYC * sdf_pkg::PHASE_DEG / sdf_pkg::QUAD_DEG;
    localparam int unsigned OFF60 = Q60_CYC * sdf_pkg::PHASE_DEG / sdf_pkg::QUAD_DEG;

    typedef struct packed {
        sdf_pkg::seq_state_type st;
        logic [1:0]             sync;
        logic [5:0]             div;
        logic [2:0]             ch;
        logic [7:0]             smp;
        logic [7:0]             ones;
        logic [16:0]            tmr;
        logic [16:0]            ph;
        logic [1:0]             q;
        logic [2:0]             fill;
        logic                   go;
        logic                   irq;
        logic [12:0]            ctl;
        logic [15:0]            channel_config_reg;
        logic [7:0][23:0]       off;
        logic [7:0][23:0]       pos;
        logic [7:0][23:0]       neg;
        logic [7:0][15:0]       res;
        logic [3:0][7:0][8:0]   avg;
        logic                   ack;
        logic [31:0]            dat;
    } state_type;

    state_type   r;
    state_type   n;
    logic        mod_en;
    logic        hum;
    logic        busy;
    logic        done;
    logic        scan_end;
    logic        req;
    logic        cal_acc;
    logic        avg_ok;
    logic [2:0]  nact;
    logic [16:0] quarter;
    logic [16:0] ph_off;
    logic [7:0]  ones_f;
    logic [9:0]  raw10;
    logic [10:0] sum;
    logic [23:0] cal_in;
    logic [1:0]  mode;
    logic [2:0]  ri;
    logic [31:0] wv;

    function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] v,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (o & ~m) | (v & m);
    endfunction

    // Offset removal, then sign-dependent slope with 800000 as unity
    function automatic logic [15:0] cal_apply(input logic [23:0] v, input logic [23:0] o,
                                              input logic [23:0] gp, input logic [23:0] gn);
        logic signed [24:0] d;
        logic [23:0]        g;
        logic signed [49:0] p;
        logic signed [26:0] s;
        d = $signed({v[23], v}) - $signed({o[23], o});
        g = d[24] ? gn : gp;
        p = d * $signed({1'b0, g});
        s = p[49:23];
        if (s > 27'sd32767) return 16'h7fff;
        if (s < -27'sd32768) return 16'h8000;
        return s[15:0];
    endfunction

    always_comb begin
        n        = r;
        hum      = r.ctl[sdf_pkg::C_HUM];
        nact     = r.ctl[sdf_pkg::C_NACT +: 3];
        quarter  = r.ctl[sdf_pkg::C_SEL60] ? Q60_CYC[16:0] : Q50_CYC[16:0];
        ph_off   = r.ctl[sdf_pkg::C_SEL60] ? OFF60[16:0] : OFF50[16:0];
        avg_ok   = r.fill == sdf_pkg::FILL_SCANS;
        mod_en   = r.div == 6'(MOD_DIV - 1);
        n.div    = mod_en ? 6'h0 : r.div + 6'h1;
        n.sync   = {r.sync[0], mod_bit_i};
        done     = 1'b0;
        scan_end = 1'b0;
        sum      = 11'h0;
        ri       = 3'h0;
        wv       = 32'h0;
        // (R15) busy only from active channels
        busy = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (3'(i) <= nact && r.channel_config_reg[2*i +: 2] != sdf_pkg::CAL_NONE) busy = 1'b1;
        end
        // (R04) quadrant timer, (R05) scan launched at 5 degrees into each quadrant
        if (!hum) begin
            n.ph = 17'h0;
            n.q  = 2'h0;
            n.go = 1'b0;
        end else begin
            n.ph = (r.ph >= quarter - 17'h1) ? 17'h0 : r.ph + 17'h1;
            n.q  = (r.ph >= quarter - 17'h1) ? r.q + 2'h1 : r.q;
            // Armed only when idle: a late scan waits a quadrant instead of drifting
            if (r.ph == ph_off && r.st == sdf_pkg::ST_IDLE) n.go = 1'b1;
        end
        ones_f = r.ones + {7'h0, r.sync[1]};
        raw10  = {1'b0, ones_f, 1'b0} - 10'(sdf_pkg::N_SAMPLES);
        case (r.st)
            sdf_pkg::ST_IDLE: begin
                n.tmr = 17'h0;
                if (!hum || r.go) begin
                    n.go = 1'b0;
                    n.st = sdf_pkg::ST_RST;
                end
            end
            // (R02) modulator and filter cleared together
            sdf_pkg::ST_RST: begin
                n.tmr  = r.tmr + 17'h1;
                n.ones = 8'h0;
                n.smp  = 8'h0;
                if (r.tmr == 17'(sdf_pkg::RST_CYC - 1)) n.st = sdf_pkg::ST_INT;
            end
            // (R01) count ones over 201 modulator samples
            sdf_pkg::ST_INT: begin
                n.tmr = r.tmr + 17'h1;
                // Skip bits still in flight from the reset phase
                if (mod_en && r.tmr >= 17'(sdf_pkg::RST_CYC + sdf_pkg::SETTLE_CYC)) begin
                    n.smp  = r.smp + 8'h1;
                    n.ones = ones_f;
                    if (r.smp == 8'(sdf_pkg::N_SAMPLES - 1)) begin
                        done = 1'b1;
                        n.st = sdf_pkg::ST_WAIT;
                    end
                end
            end
            // (R09) fixed slot per conversion; (R08) hum scan always ends at channel 7
            sdf_pkg::ST_WAIT: begin
                n.tmr = r.tmr + 17'h1;
                if (r.tmr >= 17'(SLOT_CYC - 1)) begin
                    n.tmr = 17'h0;
                    n.st  = sdf_pkg::ST_RST;
                    n.ch  = r.ch + 3'h1;
                    if (hum ? r.ch == 3'h7 : r.ch >= nact) begin
                        scan_end = 1'b1;
                        n.ch     = 3'h0;
                        n.st     = hum ? sdf_pkg::ST_IDLE : sdf_pkg::ST_RST;
                    end
                end
            end
            default: n.st = sdf_pkg::ST_RST;
        endcase
        // (R03) hum path or straight path; (R06) same-phase replacement and sum
        for (int k = 0; k < 4; k++) begin
            sum = sum + ((2'(k) == r.q) ? {{2{raw10[8]}}, raw10[8:0]}
                                        : {{2{r.avg[k][r.ch][8]}}, r.avg[k][r.ch]});
        end
        cal_in = hum ? {{13{sum[10]}}, sum} : {{15{raw10[8]}}, raw10[8:0]};
        mode   = r.channel_config_reg[2*r.ch +: 2];
        if (done) begin
            if (hum) n.avg[r.q][r.ch] = raw10[8:0];
            // (R07) hum results ignored until the array is full
            if (r.ch <= nact && (!hum || avg_ok)) begin
                // (R19) flagged conversion goes to the store; (R17) hum needs a whole cycle
                if (mode != sdf_pkg::CAL_NONE && (!hum || r.q == 2'h3)) begin
                    if (mode == sdf_pkg::CAL_ZERO) n.off[r.ch] = cal_in;
                    if (mode == sdf_pkg::CAL_POS) n.pos[r.ch] = cal_in;
                    if (mode == sdf_pkg::CAL_NEG) n.neg[r.ch] = cal_in;
                    n.channel_config_reg[2*r.ch +: 2] = sdf_pkg::CAL_NONE;
                end else begin
                    // (R10) offset and two slopes; (R12) unity stores pass raw value
                    n.res[r.ch] = cal_apply(cal_in, r.off[r.ch], r.pos[r.ch], r.neg[r.ch]);
                end
            end
        end
        if (!hum) n.fill = 3'h0;
        else if (scan_end && !avg_ok) n.fill = r.fill + 3'h1;
        // Bus slave: one wait state, registered answer
        req     = wb_req_i.cyc && wb_req_i.stb && !r.ack;
        cal_acc = req && wb_req_i.adr >= sdf_pkg::A_OFF;
        ri      = wb_req_i.adr[4:2];
        n.ack   = req;
        n.dat   = 32'h0;
        // (R20) result read clears, end of scan sets; set wins
        if (req && !wb_req_i.we && wb_req_i.adr[7:5] == sdf_pkg::A_RES[7:5]) n.irq = 1'b0;
        // (R14) scan interrupt withheld while an active channel calibrates
        if (scan_end && !(r.ctl[sdf_pkg::C_SUP] && busy) && (!hum || avg_ok)) n.irq = 1'b1;
        if (req) begin
            case ({wb_req_i.adr[7:5], 5'h0})
                sdf_pkg::A_CTRL: begin
                    if (wb_req_i.adr == sdf_pkg::A_CTRL) n.dat = {19'h0, r.ctl};
                    if (wb_req_i.adr == sdf_pkg::A_CCR) n.dat = {16'h0, r.channel_config_reg};
                    if (wb_req_i.adr == sdf_pkg::A_STAT) n.dat = {29'h0, avg_ok, busy, r.irq};
                    if (wb_req_i.we && wb_req_i.adr == sdf_pkg::A_CTRL) begin
                        wv    = wmask({19'h0, r.ctl}, wb_req_i.dat, wb_req_i.sel);
                        n.ctl = wv[12:0];
                    end
                    // (R18) software request lands after the hardware clear
                    if (wb_req_i.we && wb_req_i.adr == sdf_pkg::A_CCR) begin
                        wv    = wmask({16'h0, n.channel_config_reg}, wb_req_i.dat, wb_req_i.sel);
                        n.channel_config_reg = wv[15:0];
                    end
                end
                sdf_pkg::A_RES: n.dat = {16'h0, r.res[ri]};
                sdf_pkg::A_OFF: begin
                    n.dat = {8'h0, r.off[ri]};
                    wv    = wmask({8'h0, r.off[ri]}, wb_req_i.dat, wb_req_i.sel);
                    if (wb_req_i.we) n.off[ri] = wv[23:0];
                end
                sdf_pkg::A_POS: begin
                    n.dat = {8'h0, r.pos[ri]};
                    wv    = wmask({8'h0, r.pos[ri]}, wb_req_i.dat, wb_req_i.sel);
                    if (wb_req_i.we) n.pos[ri] = wv[23:0];
                end
                sdf_pkg::A_NEG: begin
                    n.dat = {8'h0, r.neg[ri]};
                    wv    = wmask({8'h0, r.neg[ri]}, wb_req_i.dat, wb_req_i.sel);
                    if (wb_req_i.we) n.neg[ri] = wv[23:0];
                end
                default: n.dat = 32'h0;
            endcase
        end
        // (R16) store access halts and restarts at the first channel
        if (cal_acc && wb_req_i.adr < sdf_pkg::A_NEG + 8'h20) begin
            n.st  = sdf_pkg::ST_RST;
            n.tmr = 17'h0;
            n.ch  = 3'h0;
            n.irq = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r     <= '0;
            r.st  <= sdf_pkg::ST_RST;
            r.off <= {8{sdf_pkg::OFF_RESET}};
            r.pos <= {8{sdf_pkg::GAIN_RESET}};
            r.neg <= {8{sdf_pkg::GAIN_RESET}};
        end else begin
            r <= n;
        end
    end

    assign wb_rsp_o          = '{ack: r.ack, dat: r.dat};
    assign mod_reset_o       = r.st == sdf_pkg::ST_RST;
    assign tuning_busy_pin_o = busy;
    assign scan_done_irq_n_o = ~r.irq;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_int_sample_count: assert property ( // (R01)
        r.st == sdf_pkg::ST_INT && mod_en && r.smp == 8'(sdf_pkg::N_SAMPLES - 1)
        |=> r.st == sdf_pkg::ST_WAIT || r.st == sdf_pkg::ST_RST)
        else $error("conversion did not close after 201 samples");
    a_filter_reset_clear: assert property ( // (R02)
        mod_reset_o && !$past(cal_acc) |=> r.ones == 8'h0 || !mod_reset_o)
        else $error("filter not cleared during modulator reset");
    a_hum_scan_phase: assert property ( // (R05)
        hum && r.st == sdf_pkg::ST_IDLE && $past(r.st) == sdf_pkg::ST_IDLE
        && $rose(r.go) |-> $past(r.ph) == ph_off)
        else $error("hum scan armed off phase");
    a_hum_array_write: assert property ( // (R06)
        done && hum && !cal_acc |=> r.avg[$past(r.q)][$past(r.ch)] == $past(raw10[8:0]))
        else $error("quadrant sample not replaced");
    a_hum_fill_gate: assert property ( // (R07)
        done && hum && !avg_ok |=> $stable(r.res))
        else $error("result written before averaging filled");
    a_busy_pin_active: assert property ( // (R15)
        nact == 3'h0 && r.channel_config_reg[1:0] == sdf_pkg::CAL_NONE |-> !tuning_busy_pin_o)
        else $error("busy pin high with no active calibration");
    a_irq_suppress: assert property ( // (R14)
        r.ctl[sdf_pkg::C_SUP] && busy && scan_done_irq_n_o && !req |=> scan_done_irq_n_o)
        else $error("scan interrupt not withheld while calibrating");
    a_cal_halt: assert property ( // (R16)
        cal_acc && wb_req_i.adr < sdf_pkg::A_NEG + 8'h20
        |=> r.st == sdf_pkg::ST_RST && r.ch == 3'h0 && scan_done_irq_n_o ##1 mod_reset_o)
        else $error("calibration access did not halt and restart");
    a_cal_store_clear: assert property ( // (R19)
        done && !req && r.ch <= nact && mode != sdf_pkg::CAL_NONE && !hum
        |=> r.channel_config_reg[2*$past(r.ch) +: 2] == sdf_pkg::CAL_NONE)
        else $error("mode field not cleared after calibration");
    a_irq_read_clear: assert property ( // (R20)
        req && !wb_req_i.we && wb_req_i.adr == sdf_pkg::A_RES && !scan_end && !cal_acc
        |=> scan_done_irq_n_o)
        else $error("result read left interrupt asserted");

    c_scan_irq:  cover property (scan_end ##1 !scan_done_irq_n_o);
    c_cal_store: cover property (done && mode != sdf_pkg::CAL_NONE ##1 !busy);
    c_hum_full:  cover property (hum && $rose(avg_ok));
endmodule

// ---- test/mod_model.sv ----
// Modulator bitstream model standing in front of the filter input
`timescale 1ns/1ns
module mod_model (
    input  wire logic clk_i,
    input  wire logic mod_reset_i,
    input  wire logic level_i,
    output logic      mod_bit_o
);
    initial mod_bit_o = 1'b0;
    // shared modulator reset
    // Toggles while held in reset so a stale level never looks like data
    always @(posedge clk_i) begin
        if (mod_reset_i) begin
            mod_bit_o <= ~mod_bit_o;
        end else begin
            mod_bit_o <= level_i;
        end
    end
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the filter, hum averaging and calibration sequencer
`timescale 1ns/1ns
module testbench;
    logic                clk_i;
    logic                nrst_i;
    logic                level;
    logic                mod_bit;
    logic                mod_reset;
    logic                busy;
    logic                irq_n;
    sdf_pkg::wb_req_type wb_req;
    sdf_pkg::wb_rsp_type wb_rsp;
    logic [31:0]         rd;
    int                  errors;
    int                  n_compared;
    int                  gp;
    int                  k;

    // Short slots and quarters keep both hum runs inside the cycle budget
    localparam int unsigned SLOT_TB = 800;
    localparam int unsigned Q50_TB  = 7200;
    localparam int unsigned Q60_TB  = 7000;

    sigma_delta_filter_cal_sequencer #(
        .SLOT_CYC(SLOT_TB),
        .Q50_CYC (Q50_TB),
        .Q60_CYC (Q60_TB),
        .MOD_DIV (2)
    ) i_sigma_delta_filter_cal_sequencer (
        .clk_i            (clk_i),
        .nrst_i           (nrst_i),
        .mod_bit_i        (mod_bit),
        .wb_req_i         (wb_req),
        .wb_rsp_o         (wb_rsp),
        .mod_reset_o      (mod_reset),
        .tuning_busy_pin_o(busy),
        .scan_done_irq_n_o(irq_n)
    );

    mod_model i_mod_model (
        .clk_i      (clk_i),
        .mod_reset_i(mod_reset),
        .level_i    (level),
        .mod_bit_o  (mod_bit)
    );

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic give_up(input int cnt, input int lim);
        if (cnt >= lim) begin
            errors++;
            $display("ERROR wait expected done seen timeout");
            complete_run();
        end
    endtask

    // One classic cycle; held until ack is sampled, then released
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int c;
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
        for (c = 0; c < 20; c++) begin
            @(posedge clk_i);
            if (wb_rsp.ack === 1'b1) begin
                break;
            end
        end
        rd = wb_rsp.dat;
        wb_req <= '0;
        give_up(c, 20);
    endtask

    task automatic wait_irq(input int lim, output int c);
        for (c = 0; c < lim && irq_n !== 1'b0; c++) begin
            @(posedge clk_i);
        end
        give_up(c, lim);
    endtask

    // Calibration store write: halts, clears irq, restarts at channel 0
    task automatic restart();
        wb(1'b1, sdf_pkg::A_OFF, 32'h0);
        chk_bit("irq_n after halt", 1'b1, irq_n);
        for (k = 0; k < 1000 && mod_reset === 1'b1; k++) begin
            @(posedge clk_i);
        end
        chk_word("reset phase", sdf_pkg::RST_CYC, k);
    endtask

    function automatic logic [31:0] expres(input longint v, input longint g);
        longint r;
        r = (v * g) >>> 23;
        if (r > 32767) r = 32767;
        if (r < -32768) r = -32768;
        return {16'h0000, r[15:0]};
    endfunction

    task automatic rd_res(input int ch, input logic [31:0] exp);
        wb(1'b0, sdf_pkg::A_RES + 8'(ch * 4), 32'h0);
        chk_word("result", exp, rd);
    endtask

    // Hum off then on refills the array; fifth scan lands after four quarters
    task automatic hum_run(input logic [31:0] ctl, input int q, input logic [31:0] exp);
        wb(1'b1, sdf_pkg::A_CTRL, 32'h0);
        wb(1'b1, sdf_pkg::A_CTRL, ctl);
        restart();
        wb(1'b0, sdf_pkg::A_STAT, 32'h0);
        chk_bit("average valid early", 1'b0, rd[2]);
        wait_irq(60000, k);
        chk_bit("fill time", 1'b1, k > 4 * q && k < 5 * q);
        wb(1'b0, sdf_pkg::A_STAT, 32'h0);
        chk_bit("average valid", 1'b1, rd[2]);
        rd_res(0, exp);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    initial begin
        nrst_i = 1'b0;
        level = 1'b1;
        wb_req = '0;
        errors = 0;
        n_compared = 0;
        void'($urandom(32'h46430735));
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        chk_bit("irq_n reset", 1'b1, irq_n);
        chk_bit("busy reset", 1'b0, busy);
        wb(1'b0, sdf_pkg::A_POS + 8'h04, 32'h0);
        chk_word("pos gain reset", 32'h00800000, rd);
        wb(1'b0, sdf_pkg::A_NEG, 32'h0);
        chk_word("neg gain reset", 32'h00800000, rd);
        wait_irq(30000, k);
        restart();
        wait_irq(30000, k);
        rd_res(0, 32'h000000c9);
        chk_bit("irq_n after read", 1'b1, irq_n);
        $display("test uncalibrated done");
        wb(1'b1, sdf_pkg::A_CTRL, 32'h00001000);
        // zero point first, inactive channel also flagged
        wb(1'b1, sdf_pkg::A_CCR, {20'h0, 2'(sdf_pkg::CAL_POS), 8'h0, 2'(sdf_pkg::CAL_ZERO)});
        chk_bit("busy on request", 1'b1, busy);
        for (k = 0; k < 30000 && busy === 1'b1; k++) begin
            @(posedge clk_i);
            chk_bit("irq_n while tuning", 1'b1, irq_n);
        end
        give_up(k, 30000);
        wb(1'b0, sdf_pkg::A_CCR, 32'h0);
        chk_word("mode fields", 32'h00000800, rd);
        chk_bit("busy inactive only", 1'b0, busy);
        wb(1'b0, sdf_pkg::A_OFF, 32'h0);
        chk_word("offset store", 32'h000000c9, rd);
        wait_irq(30000, k);
        rd_res(0, 32'h00000000);
        $display("test calibration done");
        // recalibrated values loaded directly by the host
        gp = 32'h00400000 + ($urandom % 32'h00800000);
        wb(1'b1, sdf_pkg::A_CCR, 32'h0);
        wb(1'b1, sdf_pkg::A_CTRL, 32'h00000004);
        wb(1'b1, sdf_pkg::A_POS, 32'(gp));
        wb(1'b1, sdf_pkg::A_NEG + 8'h04, 32'h00400000);
        restart();
        wait_irq(40000, k);
        rd_res(0, expres(201, gp));
        rd_res(1, 32'h000000c9);
        level <= 1'b0;
        restart();
        wait_irq(40000, k);
        rd_res(0, 32'h0000ff37);
        rd_res(1, 32'h0000ff9b);
        // negative point requested on an active channel
        wb(1'b1, sdf_pkg::A_CCR, {28'h0, 2'(sdf_pkg::CAL_NEG), 2'h0});
        for (k = 0; k < 30000 && busy === 1'b1; k++) begin
            @(posedge clk_i);
        end
        give_up(k, 30000);
        wb(1'b0, sdf_pkg::A_NEG + 8'h04, 32'h0);
        chk_word("neg store", 32'h00ffff37, rd);
        $display("test gains done");
        level <= 1'b1;
        hum_run(32'h00000003, Q60_TB, expres(804, gp));
        level <= 1'b0;
        hum_run(32'h00000001, Q50_TB, expres(-804, 32'h00800000));
        $display("test hum averaging done");
        complete_run();
    end
endmodule
